/* File: common/isp_pkg.sv */
package isp_pkg;
    // ==========================================================
    // addresses and bytes
    localparam logic [6:0] SLV_ADDR_RST  = 7'h42;
    localparam logic [6:0] EE_ADDR       = 7'h50;
    localparam logic [7:0] EE_WORD       = 8'h00;
    localparam logic [7:0] EE_READ_BYTE  = 8'hFF;
    localparam logic [7:0] FILLER        = 8'hFF;
    localparam logic       RW_WRITE      = 1'b0;
    localparam logic       RW_READ       = 1'b1;
    localparam logic [3:0] BYTE_BITS     = 4'h8;
    // probe byte sequence positions
    localparam logic [1:0] IDX_WR_ADDR   = 2'h0;
    localparam logic [1:0] IDX_RESTART   = 2'h1;
    localparam logic [1:0] IDX_READ      = 2'h3;
    // ==========================================================
    // timing
    localparam int  CLK_NS          = 10;
    localparam int  BIT_NS          = 10000;
    localparam int  QTR_CYC         = (BIT_NS + 4 * CLK_NS - 1)
                                      / (4 * CLK_NS);
    localparam int  QTR_W           = 9;
    localparam real POLL_IDLE_S     = 1.5;
    localparam int  POLL_IDLE_CYC   = int'(POLL_IDLE_S * 1.0e9 / CLK_NS);
    localparam int  PROBE_LIMIT_MS  = 250;
    localparam int  PROBE_LIMIT_CYC = PROBE_LIMIT_MS * 1000000 / CLK_NS;
    localparam int  CNT_W           = 28;
    // ==========================================================
    // state machines
    typedef enum logic [6:0] {
        S_IDLE     = 7'h01,
        S_ADDR     = 7'h02,
        S_ADDR_ACK = 7'h04,
        S_RX       = 7'h08,
        S_RX_ACK   = 7'h10,
        S_TX       = 7'h20,
        S_TX_ACK   = 7'h40
    } isp_slv_e;
    typedef enum logic [4:0] {
        M_IDLE  = 5'h01,
        M_START = 5'h02,
        M_BIT   = 5'h04,
        M_STOP  = 5'h08,
        M_DONE  = 5'h10
    } isp_mst_e;
endpackage

/* File: common/isp_sync_if.sv */
`timescale 1ns/1ps
interface isp_sync_if #(parameter int W = 3);
    logic [W-1:0] raw;
    logic [W-1:0] sync;
    modport syncer (input raw, output sync);
    modport user   (output raw, input sync);
endinterface

/* File: hdl/isp_sync.sv */
`timescale 1ns/1ps
module isp_sync (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic rstn,
    // pins in, synchronised levels out
    isp_sync_if.syncer port
);
    // ==========================================================
    // two flops per line; lines idle high on the bus
    logic [$bits(port.raw)-1:0] meta_q;
    logic [$bits(port.raw)-1:0] stable_q;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            meta_q   <= '1;
            stable_q <= '1;
        end else begin
            meta_q   <= port.raw;
            stable_q <= meta_q;
        end
    end

    assign port.sync = stable_q;
endmodule

/* File: hdl/isp_stream_port.sv */
`timescale 1ns/1ps
// Rules for this block, its host and the bus
// [R01] answer as slave at 7-bit address 0x42 until reconfigured
// [R02] slave address is replaced by the port configuration update
// [R03] first byte is address shifted left with read/write in bit 0
// [R04] as slave never start a transfer; the master alone clocks
// [R05] at start-up write then read EEPROM at 0xA0; ack means master
// [R06] probe only once per start-up; role then fixed
// [R07] host read with nothing pending returns 0xFF per byte
// [R08] output is a continuous stream; host drops non-message bytes
// [R09] after 1.5 s with no poll, stop loading the output buffer
// [R10] standard mode, 7-bit addressing, at most 100 kbit/s
// [R11] only pull lines low or release; never drive high
// [R12] configuration EEPROM sits at 0b1010000, 4 kB
// [R13] host EEPROM must not use address 0xA0
// [R14] EEPROM interrogation finishes within 250 ms of start-up
// [R15] flash variants never probe and stay slave
// [R16] host waits 250 ms after start-up before addressing us; the bench host waits only until probeDone
// [R17] no EEPROM master scheme with other bus contenders
// [R18] unacknowledged probe releases bus and stays slave
// [R19] pending bytes go out in order, then the filler again
module isp_stream_port #(
    parameter int POLL_CYC  = isp_pkg::POLL_IDLE_CYC,
    parameter int PROBE_CYC = isp_pkg::PROBE_LIMIT_CYC
) (
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rstn,
    // two-wire pins, open drain
    input  wire logic       sclIn,
    output      logic       sclOut,
    output      logic       sclOe,
    input  wire logic       sdaIn,
    output      logic       sdaOut,
    output      logic       sdaOe,
    // start-up strap, high on ROM variants
    input  wire logic       romStrap,
    // port_config_message address update
    input  wire logic       cfgAddrLoad,
    input  wire logic [6:0] cfgAddr,
    // output stream
    input  wire logic       txValid,
    input  wire logic [7:0] txData,
    output      logic       txPop,
    output      logic       loadHold,
    // role status
    output      logic       probeDone,
    output      logic       masterRole
);
    import isp_pkg::*;

    // ==========================================================
    // pin sampling and bus events
    isp_sync_if #(.W(3)) pinIf ();
    logic sclS, sdaS, strapS;
    logic sclPrev_q, sdaPrev_q;
    logic sclRise, sclFall, startSeen, stopSeen;

    assign pinIf.raw = {romStrap, sdaIn, sclIn};
    isp_sync u_sync (
        .core_clk (core_clk),
        .rstn     (rstn),
        .port     (pinIf.syncer)
    );
    assign sclS   = pinIf.sync[0];
    assign sdaS   = pinIf.sync[1];
    assign strapS = pinIf.sync[2];

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sclPrev_q <= 1'b1;
            sdaPrev_q <= 1'b1;
        end else begin
            sclPrev_q <= sclS;
            sdaPrev_q <= sdaS;
        end
    end
    assign sclRise   = sclS & ~sclPrev_q;
    assign sclFall   = ~sclS & sclPrev_q;
    assign startSeen = sclS & sclPrev_q & sdaPrev_q & ~sdaS;
    assign stopSeen  = sclS & sclPrev_q & ~sdaPrev_q & sdaS;

    // ==========================================================
    // start-up probe master
    isp_mst_e           mState_q, mState_d;
    logic [1:0]         mPhase_q, mPhase_d, mIdx_q, mIdx_d;
    logic [QTR_W-1:0]   mTick_q, mTick_d;
    logic [3:0]         mBit_q, mBit_d;
    logic [8:0]         mShift_q, mShift_d;
    logic               mAckOk_q, mAckOk_d;
    logic               mSclLow_q, mSclLow_d, mSdaLow_q, mSdaLow_d;
    logic               role_q, role_d, done_q, done_d;
    logic [CNT_W-1:0]   wdog_q, wdog_d;
    logic               qEnd, probing;

    function automatic logic [7:0] probeByte(input logic [1:0] idx);
        case (idx)
            2'h0:    probeByte = {EE_ADDR, RW_WRITE};
            2'h1:    probeByte = EE_WORD;
            2'h2:    probeByte = {EE_ADDR, RW_READ};
            default: probeByte = EE_READ_BYTE;
        endcase
    endfunction

    // quarter-bit tick keeps our own clock at the standard-mode rate
    assign qEnd    = mTick_q == QTR_W'(QTR_CYC - 1); // [R10]
    assign probing = mState_q inside {M_START, M_BIT, M_STOP};

    always_comb begin
        mState_d  = mState_q;
        mPhase_d  = mPhase_q;
        mIdx_d    = mIdx_q;
        mBit_d    = mBit_q;
        mShift_d  = mShift_q;
        mAckOk_d  = mAckOk_q;
        mSclLow_d = mSclLow_q;
        mSdaLow_d = mSdaLow_q;
        role_d    = role_q;
        done_d    = done_q;
        mTick_d   = qEnd ? '0 : mTick_q + 1'b1;
        wdog_d    = probing ? wdog_q + 1'b1 : wdog_q;
        if (probing && wdog_q == CNT_W'(PROBE_CYC - 1)) begin // [R14]
            mState_d  = M_DONE;
            mSclLow_d = 1'b0;
            mSdaLow_d = 1'b0;
            role_d    = 1'b0;
            done_d    = 1'b1;
        end else if (qEnd) begin
            mPhase_d = mPhase_q + 2'h1;
            case (mState_q)
                M_IDLE: begin
                    mPhase_d = 2'h0;
                    // strap is read once, well after reset release
                    if (strapS) begin // [R05]
                        mState_d = M_START;
                        mIdx_d   = IDX_WR_ADDR;
                        mAckOk_d = 1'b1;
                    end else begin // [R15]
                        mState_d = M_DONE;
                        done_d   = 1'b1;
                    end
                end
                M_START: begin
                    case (mPhase_q)
                        2'h0: mSdaLow_d = 1'b0;
                        2'h1: mSclLow_d = 1'b0;
                        2'h2: mSdaLow_d = 1'b1;
                        default: begin
                            mSclLow_d = 1'b1;
                            mState_d  = M_BIT;
                            mBit_d    = 4'h0;
                            mShift_d  = {probeByte(mIdx_q), 1'b1}; // [R03]
                        end
                    endcase
                end
                M_BIT: begin
                    case (mPhase_q)
                        2'h0: mSdaLow_d = ~mShift_q[8]; // [R11]
                        2'h1: mSclLow_d = 1'b0;
                        2'h2: begin
                            if (mBit_q == BYTE_BITS && mIdx_q != IDX_READ
                                && sdaS) begin
                                mAckOk_d = 1'b0; // [R18]
                            end
                        end
                        default: begin
                            mSclLow_d = 1'b1;
                            mShift_d  = {mShift_q[7:0], 1'b1};
                            mBit_d    = mBit_q + 4'h1;
                            if (mBit_q == BYTE_BITS) begin
                                mIdx_d = mIdx_q + 2'h1;
                                mBit_d = 4'h0;
                                if (!mAckOk_q || mIdx_q == IDX_READ) begin
                                    mState_d = M_STOP;
                                end else if (mIdx_q == IDX_RESTART) begin
                                    mState_d = M_START;
                                end else begin
                                    mShift_d = {probeByte(mIdx_d), 1'b1};
                                end
                            end
                        end
                    endcase
                end
                M_STOP: begin
                    case (mPhase_q)
                        2'h0: mSdaLow_d = 1'b1;
                        2'h1: mSclLow_d = 1'b0;
                        2'h2: mSdaLow_d = 1'b0;
                        default: begin
                            mState_d = M_DONE;
                            done_d   = 1'b1;
                            role_d   = mAckOk_q; // [R05] [R18]
                        end
                    endcase
                end
                M_DONE: mPhase_d = mPhase_q; // [R06]
                default: mState_d = M_DONE;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            mState_q  <= M_IDLE;
            mPhase_q  <= 2'h0;
            mIdx_q    <= 2'h0;
            mTick_q   <= '0;
            mBit_q    <= 4'h0;
            mShift_q  <= 9'h1FF;
            mAckOk_q  <= 1'b0;
            mSclLow_q <= 1'b0;
            mSdaLow_q <= 1'b0;
            role_q    <= 1'b0;
            done_q    <= 1'b0;
            wdog_q    <= '0;
        end else begin
            mState_q  <= mState_d;
            mPhase_q  <= mPhase_d;
            mIdx_q    <= mIdx_d;
            mTick_q   <= mTick_d;
            mBit_q    <= mBit_d;
            mShift_q  <= mShift_d;
            mAckOk_q  <= mAckOk_d;
            mSclLow_q <= mSclLow_d;
            mSdaLow_q <= mSdaLow_d;
            role_q    <= role_d;
            done_q    <= done_d;
            wdog_q    <= wdog_d;
        end
    end

    // ==========================================================
    // slave engine; it never touches scl, so no rate of its own
    isp_slv_e   sState_q, sState_d;
    logic [3:0] sBit_q, sBit_d;
    logic [7:0] sShift_q, sShift_d, nextByte;
    logic       sRead_q, sRead_d, sNack_q, sNack_d;
    logic       sSdaLow_q, sSdaLow_d;
    logic       slvEn, doLoad, popNow, pollNow;
    logic [6:0] slaveAddr_q, slaveAddr_d;

    assign slvEn    = (mState_q == M_DONE) && !role_q; // [R04]
    assign nextByte = txValid ? txData : FILLER; // [R07] [R19]

    always_comb begin
        sState_d  = sState_q;
        sBit_d    = sBit_q;
        sShift_d  = sShift_q;
        sRead_d   = sRead_q;
        sNack_d   = sNack_q;
        sSdaLow_d = sSdaLow_q;
        doLoad    = 1'b0;
        popNow    = 1'b0;
        pollNow   = 1'b0;
        if (!slvEn) begin
            sState_d  = S_IDLE;
            sSdaLow_d = 1'b0;
        end else if (startSeen) begin
            sState_d  = S_ADDR;
            sBit_d    = 4'h0;
            sSdaLow_d = 1'b0;
        end else if (stopSeen) begin
            sState_d  = S_IDLE;
            sSdaLow_d = 1'b0;
        end else begin
            case (sState_q)
                S_ADDR, S_RX: begin
                    if (sclRise) begin
                        sShift_d = {sShift_q[6:0], sdaS};
                        sBit_d   = sBit_q + 4'h1;
                    end
                    if (sclFall && sBit_q == BYTE_BITS) begin
                        sSdaLow_d = 1'b1;
                        if (sState_q == S_RX) begin
                            sState_d = S_RX_ACK;
                        end else if (sShift_q[7:1] == slaveAddr_q) begin
                            sState_d = S_ADDR_ACK; // [R01] [R03]
                            sRead_d  = sShift_q[0];
                            pollNow  = sShift_q[0];
                        end else begin
                            sSdaLow_d = 1'b0;
                            sState_d  = S_IDLE;
                        end
                    end
                end
                S_ADDR_ACK, S_RX_ACK: begin
                    if (sclFall) begin
                        if (sState_q == S_ADDR_ACK && sRead_q) begin
                            doLoad = 1'b1;
                        end else begin
                            sSdaLow_d = 1'b0;
                            sBit_d    = 4'h0;
                            sState_d  = S_RX;
                        end
                    end
                end
                S_TX: begin
                    if (sclFall) begin
                        if (sBit_q == BYTE_BITS) begin
                            sSdaLow_d = 1'b0;
                            sState_d  = S_TX_ACK;
                        end else begin
                            sSdaLow_d = ~sShift_q[6]; // [R11]
                            sShift_d  = {sShift_q[6:0], 1'b0};
                            sBit_d    = sBit_q + 4'h1;
                        end
                    end
                end
                S_TX_ACK: begin
                    if (sclRise) begin
                        sNack_d = sdaS;
                    end
                    if (sclFall) begin
                        if (sNack_q) begin
                            sState_d = S_IDLE;
                        end else begin
                            doLoad = 1'b1;
                        end
                    end
                end
                S_IDLE: sBit_d = 4'h0;
                default: sState_d = S_IDLE;
            endcase
            if (doLoad) begin // [R08] [R19]
                sShift_d  = nextByte;
                sSdaLow_d = ~nextByte[7];
                sBit_d    = 4'h1;
                sState_d  = S_TX;
                popNow    = txValid;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sState_q  <= S_IDLE;
            sBit_q    <= 4'h0;
            sShift_q  <= 8'h00;
            sRead_q   <= 1'b0;
            sNack_q   <= 1'b0;
            sSdaLow_q <= 1'b0;
        end else begin
            sState_q  <= sState_d;
            sBit_q    <= sBit_d;
            sShift_q  <= sShift_d;
            sRead_q   <= sRead_d;
            sNack_q   <= sNack_d;
            sSdaLow_q <= sSdaLow_d;
        end
    end

    // ==========================================================
    // address, poll watchdog and stream handshake
    logic [CNT_W-1:0] idleCnt_q, idleCnt_d;
    logic             hold_q, hold_d, pop_q, pop_d, idleHit;

    assign idleHit = idleCnt_q == CNT_W'(POLL_CYC - 1);

    always_comb begin
        slaveAddr_d = cfgAddrLoad ? cfgAddr : slaveAddr_q; // [R02]
        idleCnt_d   = idleCnt_q;
        if (pollNow) begin
            idleCnt_d = '0;
        end else if (slvEn && !hold_q && !idleHit) begin
            idleCnt_d = idleCnt_q + 1'b1;
        end
        // a timeout landing on a poll cycle still sets the hold;
        // the count sits at its end while held, or at zero if set on a poll, so only a fresh hit sets
        hold_d = (idleHit & ~hold_q) | (hold_q & ~pollNow); // [R09]
        pop_d  = popNow;
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            slaveAddr_q <= SLV_ADDR_RST; // [R01]
            idleCnt_q   <= '0;
            hold_q      <= 1'b0;
            pop_q       <= 1'b0;
        end else begin
            slaveAddr_q <= slaveAddr_d;
            idleCnt_q   <= idleCnt_d;
            hold_q      <= hold_d;
            pop_q       <= pop_d;
        end
    end

    // ==========================================================
    // pin drivers: enables only, the driven level is always low
    logic sclOe_q, sdaOe_q, zero_q;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sclOe_q <= 1'b0;
            sdaOe_q <= 1'b0;
            zero_q  <= 1'b0;
        end else begin
            sclOe_q <= mSclLow_d;
            sdaOe_q <= mSdaLow_d | sSdaLow_d; // [R11]
            zero_q  <= 1'b0;
        end
    end

    assign sclOut     = zero_q;
    assign sdaOut     = zero_q;
    assign sclOe      = sclOe_q;
    assign sdaOe      = sdaOe_q;
    assign txPop      = pop_q;
    assign loadHold   = hold_q;
    assign probeDone  = done_q;
    assign masterRole = role_q;

    // ==========================================================
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    addr_match_a: assert property ( // [R01] [R03]
        sState_q == S_ADDR && sclFall && sBit_q == BYTE_BITS && slvEn
        && !startSeen && !stopSeen && sShift_q[7:1] == slaveAddr_q
        |=> sState_q == S_ADDR_ACK && sdaOe_q)
        else $error("own address not acknowledged");
    addr_foreign_a: assert property ( // [R01]
        sState_q == S_ADDR && sclFall && sBit_q == BYTE_BITS && slvEn
        && !startSeen && !stopSeen && sShift_q[7:1] != slaveAddr_q
        |=> sState_q == S_IDLE && !sdaOe_q)
        else $error("foreign address acknowledged");
    addr_cfg_a: assert property ( // [R02]
        cfgAddrLoad |=> slaveAddr_q == $past(cfgAddr))
        else $error("slave address not updated");
    slave_scl_a: assert property ( // [R04]
        mState_q == M_DONE |-> !sclOe_q)
        else $error("scl pulled outside the probe");
    probe_first_a: assert property ( // [R05] [R03]
        mState_q == M_START && qEnd && mPhase_q == 2'h3
        && mIdx_q == IDX_WR_ADDR && !(wdog_q == CNT_W'(PROBE_CYC - 1))
        |=> mShift_q == {EE_ADDR, RW_WRITE, 1'b1})
        else $error("probe does not address the EEPROM");
    role_fixed_a: assert property ( // [R06]
        done_q |=> done_q && $stable(role_q) && mState_q == M_DONE)
        else $error("role changed after start-up");
    filler_byte_a: assert property ( // [R07]
        doLoad && !txValid |=> sShift_q == FILLER && !pop_q)
        else $error("filler byte not loaded");
    stream_pop_a: assert property ( // [R19] [R08]
        doLoad && txValid |=> sShift_q == $past(txData) && pop_q
        ##1 !pop_q)
        else $error("stream byte not taken once");
    hold_set_a: assert property ( // [R09]
        $rose(hold_q) |-> $past(idleCnt_q) == CNT_W'(POLL_CYC - 1))
        else $error("load hold at wrong idle count");
    poll_reset_a: assert property ( // [R09]
        pollNow |=> idleCnt_q == '0)
        else $error("poll did not restart idle count");
    open_drain_a: assert property ( // [R11]
        !sdaOut && !sclOut)
        else $error("pin driven high");
    probe_bound_a: assert property ( // [R14]
        wdog_q < CNT_W'(PROBE_CYC))
        else $error("probe overran its limit");
    flash_slave_a: assert property ( // [R15]
        mState_q == M_IDLE && qEnd && !strapS
        |=> mState_q == M_DONE && !role_q && !sclOe_q)
        else $error("flash variant probed");
    nack_slave_a: assert property ( // [R18]
        $rose(done_q) && !mAckOk_q |-> !role_q && !sdaOe_q)
        else $error("unanswered probe took master role");

    found_c: cover property ($rose(role_q));
    read_data_c: cover property (doLoad && txValid);
    read_fill_c: cover property (doLoad && !txValid);
    hold_c: cover property ($rose(hold_q));
endmodule

/* File: verif/isp_host_model.sv */
`timescale 1ns/1ps
module isp_host_model (
    // clock
    input  wire logic core_clk,
    // bus level and pulls
    input  wire logic sdaWire,
    output      logic sclPull = 1'b0,
    output      logic sdaPull = 1'b0
);
    // ==========
    // bit engine, pulls low or releases only
    task automatic wq();
        repeat (250) @(posedge core_clk); // 2.5 us quarter bit
    endtask
    task automatic start();
        sdaPull <= 1'b1;
        wq();
        sclPull <= 1'b1;
        wq();
    endtask
    task automatic stop();
        sdaPull <= 1'b1;
        wq();
        sclPull <= 1'b0;
        wq();
        sdaPull <= 1'b0;
        wq();
    endtask
    // no stretching on this bus, so scl is never waited on
    task automatic xbit(input logic tx, output logic rx);
        sdaPull <= ~tx;
        wq();
        sclPull <= 1'b0;
        wq();
        rx = sdaWire;
        wq();
        sclPull <= 1'b1;
        wq();
    endtask
    task automatic xbyte(input logic [7:0] tx, input logic ackTx,
                         output logic [7:0] rx, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            xbit(tx[i], b);
            rx[i] = b;
        end
        xbit(ackTx, b);
        ack = ~b;
    endtask
endmodule

/* File: verif/isp_stream_port_tb.sv */
`timescale 1ns/1ps
module isp_stream_port_tb;
    import isp_pkg::*;
    // ==========
    // bench signals
    logic       core_clk = 1'b0;
    logic       rstn = 1'b0;
    logic       romStrap = 1'b0;
    logic       cfgAddrLoad = 1'b0;
    logic [6:0] cfgAddr = 7'h00;
    logic       txValid = 1'b0;
    logic [7:0] txData = 8'h00;
    logic       sclOe, sdaOe, sclOut, sdaOut, txPop, loadHold;
    logic       probeDone, masterRole, sclPull, sdaPull;
    logic       sawScl = 1'b0;
    logic [7:0] shWire = 8'h00;
    logic [7:0] srcQ[$];
    logic [7:0] expQ[$];
    int         nMismatch = 0;
    int         checkCount = 0;
    int         cyc = 0;
    int         nBits = 0;
    // pull-ups give the high level
    wire logic  sclIn = ~(sclOe | sclPull);
    wire logic  sdaIn = ~(sdaOe | sdaPull);
    isp_stream_port #(.POLL_CYC(4000), .PROBE_CYC(60000)) i_isp_stream_port (
        .core_clk, .rstn, .sclIn, .sclOut, .sclOe, .sdaIn, .sdaOut,
        .sdaOe, .romStrap, .cfgAddrLoad, .cfgAddr, .txValid, .txData,
        .txPop, .loadHold, .probeDone, .masterRole);
    isp_host_model i_isp_host_model (.core_clk, .sdaWire(sdaIn),
        .sclPull, .sdaPull);
    initial forever #5 core_clk = ~core_clk;
    // ceiling well above the ~80k cycles the scenarios need
    initial begin
        wait (cyc == 95000);
        nMismatch++;
        report_and_stop();
    end
    // ==========
    // stream source, timeout and wire watch
    always @(posedge core_clk) begin
        cyc++;
        if (txPop === 1'b1) void'(srcQ.pop_front());
        txValid <= (srcQ.size() > 0);
        txData <= (srcQ.size() > 0) ? srcQ[0] : 8'h00;
        if (sclOe === 1'b1) sawScl <= 1'b1;
    end
    always @(posedge sclIn) if (nBits < 8) begin
        shWire <= {shWire[6:0], sdaIn};
        nBits++;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checkCount++;
        if (got !== exp) begin
            nMismatch++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("mismatches %0d checks %0d", nMismatch, checkCount);
        if (nMismatch == 0 && checkCount > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic do_reset(input logic rom);
        @(posedge core_clk);
        rstn <= 1'b0;
        romStrap <= rom;
        sawScl <= 1'b0;
        repeat (3) @(posedge core_clk);
        rstn <= 1'b1;
        // lines leave unknown at reset entry; count bits only from here
        nBits = 0;
    endtask
    task automatic wait_done();
        // host stays off the bus until the role is settled
        // and no other contender is present meanwhile
        repeat (70000) if (probeDone !== 1'b1) @(posedge core_clk);
    endtask
    task automatic host_read(input logic [6:0] a, input int n,
                             input logic expAck);
        logic [7:0] b;
        logic       k;
        logic       d;
        i_isp_host_model.start();
        i_isp_host_model.xbyte({a, RW_READ}, 1'b1, b, k);
        chk(8'(k), 8'(expAck));
        if (k) chk(8'(loadHold), 8'h00);
        for (int i = 0; i < n && k; i++) begin
            i_isp_host_model.xbyte(8'hFF, i == n - 1, b, d);
            chk(b, expQ.pop_front());
        end
        i_isp_host_model.stop();
    endtask
    // ==========
    // scenarios
    task automatic t_probe_absent();
        do_reset(1'b1);
        wait_done();
        chk(8'(probeDone), 8'h01);
        chk(8'(masterRole), 8'h00);
        chk(8'(sawScl), 8'h01);
        chk(shWire, {EE_ADDR, RW_WRITE});
        sawScl <= 1'b0;
    endtask
    task automatic t_stream();
        srcQ.push_back(8'h3C);
        srcQ.push_back(8'hA5);
        expQ = '{8'h3C, 8'hA5, FILLER};
        host_read(SLV_ADDR_RST, 3, 1'b1);
        chk(8'(srcQ.size()), 8'h00);
    endtask
    task automatic t_cfg_addr();
        @(posedge core_clk);
        cfgAddrLoad <= 1'b1;
        cfgAddr <= 7'h21;
        @(posedge core_clk);
        cfgAddrLoad <= 1'b0;
        host_read(7'h21, 0, 1'b1);
        chk(8'(loadHold), 8'h00);
        host_read(SLV_ADDR_RST, 0, 1'b0);
        chk(8'(loadHold), 8'h01);
        chk(8'(sawScl), 8'h00);
    endtask
    task automatic t_flash();
        do_reset(1'b0);
        wait_done();
        chk(8'(masterRole), 8'h00);
        host_read(SLV_ADDR_RST, 0, 1'b1);
        chk(8'(sawScl), 8'h00);
        chk({6'h00, sclOut, sdaOut}, 8'h00);
    endtask
    initial begin
        t_probe_absent();
        t_stream();
        t_cfg_addr();
        t_flash();
        report_and_stop();
    end
endmodule
